// *** verilog/pcps_consts.svh ***
// Constants of the plate column pulse sequencer
`ifndef PCPS_CONSTS_SVH
`define PCPS_CONSTS_SVH
// ****************************************
// Clock and timing
// ****************************************
`define PCPS_CLK_HZ 20000000
`define PCPS_TICK_US 1000
`define PCPS_TICK_CYC (`PCPS_TICK_US * (`PCPS_CLK_HZ / 1000000))
`define PCPS_DB_MS 10
`define PCPS_DB_TICKS (`PCPS_DB_MS * 1000 / `PCPS_TICK_US)
`define PCPS_RPT_DLY_MS 500
`define PCPS_RPT_DLY_TICKS (`PCPS_RPT_DLY_MS * 1000 / `PCPS_TICK_US)
`define PCPS_RPT_RATE_MS 100
`define PCPS_RPT_RATE_TICKS (`PCPS_RPT_RATE_MS * 1000 / `PCPS_TICK_US)
`define PCPS_BLINK_MS 250
`define PCPS_BLINK_TICKS (`PCPS_BLINK_MS * 1000 / `PCPS_TICK_US)
`define PCPS_BEEP_MS 100
`define PCPS_BEEP_TICKS (`PCPS_BEEP_MS * 1000 / `PCPS_TICK_US)
// ****************************************
// Ranges and reset values
// ****************************************
`define PCPS_COL_FIRST 4'h1
`define PCPS_COL_LAST 4'hc
`define PCPS_TGT_MIN 7'h01
`define PCPS_TGT_MAX 7'h63
`define PCPS_TGT_RST 7'h00
`define PCPS_BEEP_PHASES 3'h6
// ****************************************
// Register map
// ****************************************
`define PCPS_OFF_CTRL 8'h00
`define PCPS_OFF_STATUS 8'h04
`define PCPS_OFF_IRQ_STAT 8'h08
`define PCPS_OFF_IRQ_MASK 8'h0c
`define PCPS_OFF_DONE 8'h10
`define PCPS_CTRL_RST 2'h1
`define PCPS_CTRL_BEEP_BIT 0
`define PCPS_CTRL_LOCK_BIT 1
`define PCPS_IRQ_COL 0
`define PCPS_IRQ_FIN 1
`define PCPS_IRQ_CLOSE 2
`define PCPS_IRQ_OPEN 3
`endif

// *** verilog/pcps_pkg.sv ***
// Types of the plate column pulse sequencer
package pcps_pkg;
  typedef enum logic [1:0] {RUN_OPEN, RUN_ARMED, RUN_ACTIVE, RUN_DONE}
    pcps_run_e;
endpackage

// *** verilog/pcps_sync.sv ***
// Three-stage synchroniser with lockout debounce
`timescale 1ns/10ps
module pcps_sync #(
  parameter int N = 6,
  parameter int LOCK = 10
) (
  // Clock, reset, tick
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick,
  // Raw and clean levels, clean rising edges
  input wire logic [N-1:0] din,
  output logic [N-1:0] q_o,
  output logic [N-1:0] rise_o
);
  localparam int LW = $clog2(LOCK + 1);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      logic s1_r, s2_r, s3_r;
      logic [LW-1:0] lock_r;
      wire agree = (s2_r == s3_r);
      wire change = agree && (s3_r != q_o[i]) && (lock_r == '0);
      always_ff @(posedge clk) begin
        if (!rstn) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          q_o[i] <= 1'b0;
          rise_o[i] <= 1'b0;
          lock_r <= '0;
        end else begin
          s1_r <= din[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          rise_o[i] <= change && s3_r;
          if (change) begin
            q_o[i] <= s3_r;
            lock_r <= LW'(LOCK);
          end else if (tick && lock_r != '0) begin
            lock_r <= lock_r - LW'(1);
          end
        end
      end
      property p_sync_agree;
        @(posedge clk) disable iff (!rstn)
          (q_o[i] != $past(q_o[i])) |-> $past(s2_r == s3_r && lock_r == '0);
      endproperty
      a_sync_agree: assert property (p_sync_agree)
        else $error("clean level changed without agreement");
    end
  endgenerate
endmodule

// *** verilog/pcps_repeat.sv ***
// Button step generator with delayed auto-repeat
`timescale 1ns/10ps
module pcps_repeat #(
  parameter int DLY = 500,
  parameter int RATE = 100
) (
  // Clock, reset, tick
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick,
  // Button
  input wire logic held,
  input wire logic press,
  output logic step_o
);
  localparam int CW = $clog2(DLY + RATE + 1);
  logic [CW-1:0] cnt_r;
  logic rep_r;
  wire dly_end = !rep_r && (cnt_r == CW'(DLY - 1));
  wire rate_end = rep_r && (cnt_r == CW'(RATE - 1));
  always_ff @(posedge clk) begin
    if (!rstn) begin
      step_o <= 1'b0;
      cnt_r <= '0;
      rep_r <= 1'b0;
    end else begin
      step_o <= 1'b0;
      if (press) begin
        step_o <= 1'b1;
        cnt_r <= '0;
        rep_r <= 1'b0;
      end else if (held && tick) begin
        if (dly_end || rate_end) begin
          step_o <= 1'b1;
          cnt_r <= '0;
          rep_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + CW'(1);
        end
      end
    end
  end
  property p_step_held;
    @(posedge clk) disable iff (!rstn) step_o |-> $past(held);
  endproperty
  a_step_held: assert property (p_step_held)
    else $error("step without held button");
  property p_rep_only_held;
    @(posedge clk) disable iff (!rstn)
      (step_o && !$past(press)) |-> $past(rep_r || dly_end);
  endproperty
  a_rep_only_held: assert property (p_rep_only_held)
    else $error("repeat step before initial delay");
endmodule

// *** verilog/pcps_top.sv ***
// Plate column pulse sequencer top with APB registers
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "pcps_consts.svh"
module pcps_top #(
  parameter int TICK_CYC = `PCPS_TICK_CYC,
  parameter int DB_TICKS = `PCPS_DB_TICKS,
  parameter int RPT_DLY = `PCPS_RPT_DLY_TICKS,
  parameter int RPT_RATE = `PCPS_RPT_RATE_TICKS,
  parameter int BLINK_TICKS = `PCPS_BLINK_TICKS,
  parameter int BEEP_TICKS = `PCPS_BEEP_TICKS
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Panel inputs
  input wire logic PULSE_DET,
  input wire logic LID_CLOSED,
  input wire logic COL_UP_N,
  input wire logic COL_DN_N,
  input wire logic PLS_UP_N,
  input wire logic PLS_DN_N,
  // Panel outputs
  output logic [11:0] COL_LED,
  output logic [3:0] COL_NUM,
  output logic [6:0] REMAIN,
  output logic [6:0] TARGET,
  output logic BEEP,
  output logic IRQ
);
  localparam int TW = $clog2(TICK_CYC);
  localparam int BW = $clog2(BLINK_TICKS + BEEP_TICKS + 1);

  function automatic logic [11:0] col_onehot(input logic [3:0] c);
    logic [11:0] oh;
    oh = '0;
    for (int k = 0; k < 12; k++) begin
      oh[k] = (c == 4'(k + 1));
    end
    return oh;
  endfunction

  // ****************************************
  // Millisecond tick
  // ****************************************
  logic [TW-1:0] tick_cnt_r;
  logic tick_r;
  wire tick_wrap = (tick_cnt_r == TW'(TICK_CYC - 1));
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + TW'(1);
      tick_r <= tick_wrap;
    end
  end

  // ****************************************
  // Input conditioning
  // ****************************************
  logic [5:0] in_q, in_rise;
  logic [3:0] step;
  logic lid_prev_r;
  wire [5:0] raw_in = {~PLS_DN_N, ~PLS_UP_N, ~COL_DN_N, ~COL_UP_N,
                       LID_CLOSED, PULSE_DET};
  pcps_sync #(.N(6), .LOCK(DB_TICKS)) u_sync (
    .clk(MCLK),
    .rstn(RSTN),
    .tick(tick_r),
    .din(raw_in),
    .q_o(in_q),
    .rise_o(in_rise)
  );
  genvar j;
  generate
    for (j = 0; j < 4; j++) begin : g_btn
      pcps_repeat #(.DLY(RPT_DLY), .RATE(RPT_RATE)) u_rpt (
        .clk(MCLK),
        .rstn(RSTN),
        .tick(tick_r),
        .held(in_q[j + 2]),
        .press(in_rise[j + 2]),
        .step_o(step[j])
      );
    end
  endgenerate
  wire pulse_ev = in_rise[0];
  wire lid_close = in_q[1] && !lid_prev_r;
  wire lid_open = !in_q[1] && lid_prev_r;

  // ****************************************
  // Registers of the APB slave
  // ****************************************
  logic [1:0] ctrl_r;
  logic [3:0] istat_r, imask_r;
  logic [11:0] done_r;
  logic [3:0] col_r;
  logic [6:0] rem_r, tgt_r;
  pcps_pkg::pcps_run_e run_r;
  wire setup = PSEL && !PENABLE;
  wire acc = PSEL && PENABLE && PREADY;
  wire wr = acc && PWRITE;
  wire a_ctrl = (PADDR == `PCPS_OFF_CTRL);
  wire a_stat = (PADDR == `PCPS_OFF_STATUS);
  wire a_ist = (PADDR == `PCPS_OFF_IRQ_STAT);
  wire a_imk = (PADDR == `PCPS_OFF_IRQ_MASK);
  wire a_done = (PADDR == `PCPS_OFF_DONE);
  wire hit = a_ctrl || a_stat || a_ist || a_imk || a_done;
  wire [31:0] status_w = {6'h00, run_r, 1'b0, tgt_r, 1'b0, rem_r,
                          4'h0, col_r};
  logic [31:0] rdata;
  always_comb begin
    if (a_ctrl) begin
      rdata = {30'h0, ctrl_r};
    end else if (a_stat) begin
      rdata = status_w;
    end else if (a_ist) begin
      rdata = {28'h0, istat_r};
    end else if (a_imk) begin
      rdata = {28'h0, imask_r};
    end else if (a_done) begin
      rdata = {20'h0, done_r};
    end else begin
      rdata = 32'h0;
    end
  end

  // ****************************************
  // Column and pulse sequencing
  // ****************************************
  pcps_pkg::pcps_run_e run_nxt;
  logic [3:0] col_nxt;
  logic [6:0] rem_nxt, tgt_nxt;
  logic [11:0] done_nxt;
  logic col_ev, fin_ev;
  wire btn_ok = !ctrl_r[`PCPS_CTRL_LOCK_BIT];
  wire adj_ok = btn_ok && (run_r == pcps_pkg::RUN_OPEN ||
                           run_r == pcps_pkg::RUN_ARMED);
  always_comb begin
    run_nxt = run_r;
    col_nxt = col_r;
    rem_nxt = rem_r;
    tgt_nxt = tgt_r;
    done_nxt = done_r;
    col_ev = 1'b0;
    fin_ev = 1'b0;
    if (adj_ok) begin
      if (step[0] && col_r != `PCPS_COL_LAST) begin
        col_nxt = col_r + 4'h1;
      end else if (step[1] && col_r != `PCPS_COL_FIRST) begin
        col_nxt = col_r - 4'h1;
      end
      if (step[2]) begin
        tgt_nxt = (tgt_r >= `PCPS_TGT_MAX) ? `PCPS_TGT_MAX
                                           : tgt_r + 7'h01;
      end else if (step[3]) begin
        tgt_nxt = (tgt_r <= `PCPS_TGT_MIN) ? `PCPS_TGT_MIN
                                           : tgt_r - 7'h01;
      end
      rem_nxt = tgt_nxt;
    end
    case (run_r)
      pcps_pkg::RUN_OPEN: begin
        if (lid_close) begin
          run_nxt = pcps_pkg::RUN_ARMED;
          col_nxt = `PCPS_COL_FIRST;
        end
      end
      pcps_pkg::RUN_ARMED, pcps_pkg::RUN_ACTIVE: begin
        if (pulse_ev && tgt_r != 7'h00) begin
          run_nxt = pcps_pkg::RUN_ACTIVE;
          if (rem_r <= 7'h01) begin
            rem_nxt = tgt_r;
            done_nxt = done_r | col_onehot(col_r);
            col_ev = 1'b1;
            if (col_r == `PCPS_COL_LAST) begin
              run_nxt = pcps_pkg::RUN_DONE;
              fin_ev = 1'b1;
            end else begin
              col_nxt = col_r + 4'h1;
            end
          end else begin
            rem_nxt = rem_r - 7'h01;
          end
        end
      end
      default: begin
      end
    endcase
    if (lid_open) begin
      run_nxt = pcps_pkg::RUN_OPEN;
      done_nxt = 12'h000;
    end
  end
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      run_r <= pcps_pkg::RUN_OPEN;
      col_r <= `PCPS_COL_FIRST;
      rem_r <= `PCPS_TGT_RST;
      tgt_r <= `PCPS_TGT_RST;
      done_r <= 12'h000;
      lid_prev_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      col_r <= col_nxt;
      rem_r <= rem_nxt;
      tgt_r <= tgt_nxt;
      done_r <= done_nxt;
      lid_prev_r <= in_q[1];
    end
  end

  // ****************************************
  // LEDs and beeper
  // ****************************************
  logic [BW-1:0] blk_cnt_r, bp_cnt_r;
  logic blink_r;
  logic [2:0] bp_ph_r;
  wire show = (run_r == pcps_pkg::RUN_ARMED || run_r == pcps_pkg::RUN_ACTIVE);
  wire blk_end = (blk_cnt_r == BW'(BLINK_TICKS - 1));
  wire bp_end = (bp_cnt_r == BW'(BEEP_TICKS - 1));
  wire [11:0] led_nxt = done_r |
                        (col_onehot(col_r) & {12{blink_r && show}});
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      blk_cnt_r <= '0;
      blink_r <= 1'b0;
      bp_cnt_r <= '0;
      bp_ph_r <= 3'h0;
    end else begin
      if (tick_r) begin
        blk_cnt_r <= blk_end ? '0 : blk_cnt_r + BW'(1);
        blink_r <= blink_r ^ blk_end;
      end
      if (fin_ev) begin
        bp_ph_r <= `PCPS_BEEP_PHASES;
        bp_cnt_r <= '0;
      end else if (tick_r && bp_ph_r != 3'h0) begin
        bp_cnt_r <= bp_end ? '0 : bp_cnt_r + BW'(1);
        bp_ph_r <= bp_end ? bp_ph_r - 3'h1 : bp_ph_r;
      end
    end
  end

  // ****************************************
  // Bus answer, interrupt and outputs
  // ****************************************
  wire [3:0] ev = {lid_open, lid_close, fin_ev, col_ev};
  wire [3:0] w1c = (wr && a_ist) ? PWDATA[3:0] : 4'h0;
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
      ctrl_r <= `PCPS_CTRL_RST;
      imask_r <= 4'h0;
      istat_r <= 4'h0;
      IRQ <= 1'b0;
      COL_LED <= 12'h000;
      COL_NUM <= `PCPS_COL_FIRST;
      REMAIN <= `PCPS_TGT_RST;
      TARGET <= `PCPS_TGT_RST;
      BEEP <= 1'b0;
    end else begin
      PREADY <= setup;
      PRDATA <= setup ? rdata : PRDATA;
      PSLVERR <= setup && !hit;
      if (wr && a_ctrl) ctrl_r <= PWDATA[1:0];
      if (wr && a_imk) imask_r <= PWDATA[3:0];
      istat_r <= (istat_r & ~w1c) | ev;
      IRQ <= |(istat_r & imask_r);
      COL_LED <= led_nxt;
      COL_NUM <= col_r;
      REMAIN <= rem_r;
      TARGET <= tgt_r;
      BEEP <= ctrl_r[`PCPS_CTRL_BEEP_BIT] && bp_ph_r != 3'h0 &&
              !bp_ph_r[0];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  property p_col_range;
    col_r >= `PCPS_COL_FIRST && col_r <= `PCPS_COL_LAST;
  endproperty
  a_col_range: assert property (p_col_range)
    else $error("column out of range");
  property p_lid_load;
    (run_r == pcps_pkg::RUN_OPEN && lid_close) |=> col_r == 4'h1 ##1
      COL_NUM == 4'h1;
  endproperty
  a_lid_load: assert property (p_lid_load)
    else $error("lid close did not load column one");
  property p_tgt_range;
    $past(tgt_r) != 7'h00 |-> tgt_r >= 7'h01 && tgt_r <= 7'h63;
  endproperty
  a_tgt_range: assert property (p_tgt_range)
    else $error("target out of range");
  property p_tgt_rst;
    $past(!RSTN) |-> tgt_r == 7'h00 && TARGET == 7'h00;
  endproperty
  a_tgt_rst: assert property (p_tgt_rst)
    else $error("target not zero after reset");
  property p_count_down;
    (pulse_ev && show && tgt_r != 7'h00 && rem_r > 7'h01 && !lid_open)
      |=> rem_r == $past(rem_r) - 7'h01 ##1 REMAIN == $past(rem_r);
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("pulse did not decrement count");
  property p_reload_adv;
    (pulse_ev && show && tgt_r != 7'h00 && rem_r == 7'h01 &&
     col_r != 4'hc && !lid_open)
      |=> rem_r == $past(tgt_r) && col_r == $past(col_r) + 4'h1;
  endproperty
  a_reload_adv: assert property (p_reload_adv)
    else $error("no reload and advance at zero");
  property p_blink;
    (show && !lid_open && !$past(lid_open)) ##1 (blink_r && show)
      |=> COL_LED[col_r - 4'h1] || $past(col_r) != col_r;
  endproperty
  a_blink: assert property (p_blink)
    else $error("active column LED not lit in blink phase");
  property p_done_hold;
    (in_q[1] && $past(in_q[1])) |-> (done_r & $past(done_r)) ==
      $past(done_r);
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("finished column mark lost while closed");
  property p_open_clear;
    lid_open |=> done_r == 12'h000 ##1
      COL_LED == 12'h000;
  endproperty
  a_open_clear: assert property (p_open_clear)
    else $error("cover open did not clear marks");
  property p_beep_start;
    fin_ev |=> bp_ph_r == 3'h6 ##1 BEEP == $past(ctrl_r[0]);
  endproperty
  a_beep_start: assert property (p_beep_start)
    else $error("beep sequence did not start");
  property p_stop;
    (run_r == pcps_pkg::RUN_DONE && !lid_open) |=>
      $stable(col_r) && $stable(rem_r);
  endproperty
  a_stop: assert property (p_stop)
    else $error("sequencer moved after completion");
  c_col_adv: cover property (col_ev && !fin_ev);
  c_finish: cover property (fin_ev);
  c_reopen: cover property (lid_open && done_r != 12'h000);
  c_apb_err: cover property (PSLVERR);
endmodule

// *** testbench/pcps_panel.sv ***
// Operator panel and pulse generator model
`timescale 1ns/10ps
module pcps_panel (
  // Clock
  input wire logic clk,
  // Panel pins
  output logic pulse_det,
  output logic lid_closed,
  output logic col_up_n,
  output logic col_dn_n,
  output logic pls_up_n,
  output logic pls_dn_n
);
  // ****************************************
  // Pin levels, buttons idle high
  // ****************************************
  logic [5:0] pin = 6'h3c;
  assign {pls_dn_n, pls_up_n, col_dn_n, col_up_n} = pin[5:2];
  assign lid_closed = pin[1];
  assign pulse_det = pin[0];
  // ****************************************
  // Actions
  // ****************************************
  task automatic hold(input int k, input logic v, input int cyc);
    @(posedge clk);
    pin[k] <= v;
    repeat (cyc) @(posedge clk);
  endtask
  task automatic press(input int k, input int cyc);
    hold(k, 1'b0, cyc);
    hold(k, 1'b1, 40);
  endtask
  task automatic lid(input logic v);
    hold(1, v, 40);
  endtask
  // One generator pulse with a one-cycle bounce
  task automatic pulse();
    hold(0, 1'b1, 5);
    hold(0, 1'b0, 0);
    hold(0, 1'b1, 10);
    hold(0, 1'b0, 30);
  endtask
endmodule

// *** testbench/test_pcps_top.sv ***
// Self-checking bench of the plate column pulse sequencer
`timescale 1ns/10ps
module test_pcps_top;
  logic MCLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, BEEP, IRQ;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic PULSE_DET, LID_CLOSED, COL_UP_N, COL_DN_N, PLS_UP_N, PLS_DN_N;
  logic [11:0] COL_LED;
  logic [3:0] COL_NUM;
  logic [6:0] REMAIN, TARGET;
  logic er, on, off;
  int errors = 0;
  int compares = 0;
  int beeps = 0;
  pcps_top #(.TICK_CYC(4), .DB_TICKS(2), .RPT_DLY(8), .RPT_RATE(4),
    .BLINK_TICKS(4)) u_pcps_top (.MCLK(MCLK),
    .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PULSE_DET(PULSE_DET), .LID_CLOSED(LID_CLOSED),
    .COL_UP_N(COL_UP_N), .COL_DN_N(COL_DN_N), .PLS_UP_N(PLS_UP_N),
    .PLS_DN_N(PLS_DN_N), .COL_LED(COL_LED), .COL_NUM(COL_NUM),
    .REMAIN(REMAIN), .TARGET(TARGET), .BEEP(BEEP), .IRQ(IRQ));
  pcps_panel u_pcps_panel (.clk(MCLK), .pulse_det(PULSE_DET),
    .lid_closed(LID_CLOSED), .col_up_n(COL_UP_N), .col_dn_n(COL_DN_N),
    .pls_up_n(PLS_UP_N), .pls_dn_n(PLS_DN_N));
  // ****************************************
  // Clock and beep counter
  // ****************************************
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  always @(posedge BEEP) beeps++;
  // ****************************************
  // Tasks
  // ****************************************
  task print_verdict();
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h got %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 20) begin
      errors++;
      print_verdict();
    end
  endtask
  task pulses(input int n);
    repeat (n) u_pcps_panel.pulse();
  endtask
  task blink(input int k);
    on = 1'b0;
    off = 1'b0;
    repeat (40) begin
      @(posedge MCLK);
      on = on | COL_LED[k];
      off = off | !COL_LED[k];
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    RSTN = 1'b0;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    repeat (20) @(posedge MCLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge MCLK);
    chk("target", 7'h00, TARGET);
    chk("col", 4'h1, COL_NUM);
    chk("leds", 12'h000, COL_LED);
    apb(1'b0, 8'h00, 0);
    chk("ctrl", 32'h1, rd);
    apb(1'b0, 8'h20, 0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_data", 32'h0, rd);
    u_pcps_panel.lid(1'b1);
    pulses(1);
    chk("remain_t0", 7'h00, REMAIN);
    u_pcps_panel.lid(1'b0);
    u_pcps_panel.press(5, 16);
    chk("target_dn", 7'h01, TARGET);
    u_pcps_panel.press(4, 1800);
    chk("target_max", 7'h63, TARGET);
    u_pcps_panel.press(5, 1800);
    chk("target_min", 7'h01, TARGET);
    u_pcps_panel.press(4, 16);
    chk("target_up", 7'h02, TARGET);
    u_pcps_panel.press(3, 16);
    chk("col_floor", 4'h1, COL_NUM);
    u_pcps_panel.press(2, 1800);
    chk("col_max", 4'hc, COL_NUM);
    u_pcps_panel.lid(1'b1);
    chk("col_lid", 4'h1, COL_NUM);
    chk("remain_lid", 7'h02, REMAIN);
    blink(0);
    chk("blink1", 2'h3, {on, off});
    u_pcps_panel.press(2, 1800);
    u_pcps_panel.press(3, 16);
    chk("col_11", 4'hb, COL_NUM);
    apb(1'b1, 8'h0c, 32'h1);
    pulses(1);
    chk("remain_dec", 7'h01, REMAIN);
    chk("irq_masked", 1'b0, IRQ);
    pulses(1);
    chk("remain_reload", 7'h02, REMAIN);
    chk("col_adv", 4'hc, COL_NUM);
    blink(10);
    chk("steady", 2'h2, {on, off});
    chk("irq_set", 1'b1, IRQ);
    apb(1'b0, 8'h08, 0);
    chk("irq_stat", 32'h1, rd & 32'h1);
    apb(1'b1, 8'h08, 32'h1);
    repeat (4) @(posedge MCLK);
    chk("irq_clr", 1'b0, IRQ);
    blink(11);
    chk("blink12", 2'h3, {on, off});
    beeps = 0;
    pulses(2);
    repeat (2600) @(posedge MCLK);
    chk("beeps", 3, beeps);
    apb(1'b0, 8'h04, 0);
    chk("run_done", 2'h3, rd[25:24]);
    apb(1'b0, 8'h10, 0);
    chk("done_mask", 32'hc00, rd);
    chk("leds_done", 12'hc00, COL_LED);
    pulses(1);
    chk("col_end", 4'hc, COL_NUM);
    chk("remain_end", 7'h02, REMAIN);
    u_pcps_panel.lid(1'b0);
    chk("leds_open", 12'h000, COL_LED);
    apb(1'b0, 8'h10, 0);
    chk("done_open", 32'h0, rd);
    apb(1'b1, 8'h00, 32'h3);
    u_pcps_panel.press(4, 16);
    chk("target_lock", 7'h02, TARGET);
    apb(1'b0, 8'h00, 0);
    chk("ctrl_lock", 32'h3, rd);
    print_verdict();
  end
endmodule
